// file: common/gtr_regs.vh
// register map, field layout, reset values and action codes of the trigger block
`ifndef GTR_REGS_VH
`define GTR_REGS_VH

// byte offsets on the register bus
`define GTR_OFF_CTRL 8'h00
`define GTR_OFF_GPI_CFG 8'h04
`define GTR_OFF_CMD 8'h08
`define GTR_OFF_STATUS 8'h0c
`define GTR_OFF_MASK 8'h10
`define GTR_OFF_STATE 8'h14

// control register fields
`define GTR_CTRL_RUN_LSB 0
`define GTR_CTRL_RUN_MSB 1
`define GTR_CTRL_SER_LSB 4
`define GTR_CTRL_SER_MSB 6

// per-input configuration byte, input n at bits 8n+7..8n
`define GTR_CFG_LANE 8
`define GTR_CFG_ACT_LSB 0
`define GTR_CFG_ACT_MSB 3
`define GTR_CFG_EDGE_BIT 4
`define GTR_CFG_POL_BIT 5

// command register bits, each a one-shot on write
`define GTR_CMD_RUN_SAVE 0
`define GTR_CMD_RUN_USER 1
`define GTR_CMD_RUN_FACT 2
`define GTR_CMD_EXT_SAVE 3
`define GTR_CMD_EXT_USER 4
`define GTR_CMD_EXT_FACT 5
`define GTR_CMD_RUN_REQ 6

// status and mask layout
`define GTR_ST_GPI_LSB 0
`define GTR_ST_GPI_MSB 3
`define GTR_ST_RUN_BIT 4
`define GTR_ST_WIDTH 5

// run start settings
`define GTR_RUN_ANY 2'h0
`define GTR_RUN_ODD 2'h1
`define GTR_RUN_EVEN 2'h2

// factory defaults
`define GTR_FACT_RUN 2'h0
`define GTR_FACT_SER 3'h7
`define GTR_FACT_GPI 32'h00000000
`define GTR_RST_MASK 5'h0

// assigned actions
`define GTR_ACT_OFF 4'h0
`define GTR_ACT_REWIND 4'h1
`define GTR_ACT_RUN 4'h2
`define GTR_ACT_STOP 4'h3
`define GTR_ACT_FREEZE 4'h4
`define GTR_ACT_REVERSE 4'h5
`define GTR_ACT_STEP_NEXT_KEYFRAME 4'h6
`define GTR_ACT_STEP_PREVIOUS_KEYFRAME 4'h7
`define GTR_ACT_REWIND_JITTER 4'h8
`define GTR_ACT_STEP_JITTER 4'h9
`define GTR_ACT_FADE 4'ha
`define GTR_ACT_ADV_FRAME 4'hb
`define GTR_ACT_REV_FRAME 4'hc
`define GTR_ACT_ADV_FIELD 4'hd
`define GTR_ACT_REV_FIELD 4'he

// axi responses
`define GTR_RESP_OKAY 2'h0
`define GTR_RESP_SLVERR 2'h2

`endif

// file: verilog/gtr_gpi_chan.v
// one trigger input: synchroniser, once-per-field sampling and activation detect
module gtr_gpi_chan (
  input wire clk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire ce, // clock enable
  input wire gpi_pin, // trigger input line
  input wire field_tick, // one-cycle pulse at each field start
  input wire mode_edge, // 1 edge-sensitive, 0 level-sensitive
  input wire pol_high, // level mode: 1 active high, 0 active low
  input wire enabled, // input has an action assigned
  input wire [3:0] act_code, // assigned action
  output reg fire, // one-cycle activation pulse
  output reg [3:0] fire_code, // action issued with fire
  output wire sampled // last field sample of the line
);

  reg sync1_reg;
  reg sync2_reg;
  reg raw0_reg;
  reg lvl0_reg;
  reg lvl1_reg;
  wire lvl_now;
  wire edge_hit;
  wire level_hit;

  // polarity is applied only on the level path
  assign lvl_now = pol_high ? sync2_reg : ~sync2_reg; // (RULE6)
  assign edge_hit = sync2_reg & ~raw0_reg; // (RULE5)
  // second consecutive active field, once per stretch
  assign level_hit = lvl_now & lvl0_reg & ~lvl1_reg; // (RULE3)
  assign sampled = raw0_reg;

  // history resets as if active so nothing fires straight out of reset
  always @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      raw0_reg <= 1'b1;
      lvl0_reg <= 1'b1;
      lvl1_reg <= 1'b1;
      fire <= 1'b0;
      fire_code <= 4'h0;
    end else if (ce) begin
      sync1_reg <= gpi_pin; // (RULE14)
      sync2_reg <= sync1_reg;
      fire <= 1'b0;
      if (field_tick) begin
        raw0_reg <= sync2_reg;
        lvl0_reg <= lvl_now;
        lvl1_reg <= lvl0_reg;
        if (enabled && (mode_edge ? edge_hit : level_hit)) begin // (RULE2) (RULE8)
          fire <= 1'b1; // (RULE14)
          fire_code <= act_code; // (RULE7)
        end
      end
    end
  end

endmodule

// file: verilog/gtr_run_start.v
// effect run scheduler: starts a requested run on the chosen field parity
module gtr_run_start (
  input wire clk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire ce, // clock enable
  input wire field_tick, // one-cycle pulse at each field start
  input wire field_odd, // parity of the field that starts at field_tick
  input wire [1:0] run_mode, // any, odd or even
  input wire req, // run request pulse
  output reg start, // one-cycle run start pulse
  output wire pending // a request waits for its field
);

`include "gtr_regs.vh"

  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg go;

  assign pending = state_reg[1];

  always @* begin
    case (run_mode)
      `GTR_RUN_ODD: go = field_tick & field_odd; // (RULE11)
      `GTR_RUN_EVEN: go = field_tick & ~field_odd; // (RULE11)
      default: go = field_tick; // (RULE10)
    endcase
  end

  // a request in the tick cycle waits for the following field
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (go) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      start <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      start <= (state_reg == ST_WAIT) && go;
    end
  end

endmodule

// file: verilog/gtr_top.v
// trigger inputs, serial-port enables and run start timing behind an axi4-lite slave
//
// Contract
// (RULE1) four trigger inputs, each configured separately
// (RULE2) per input choose level or edge detection
// (RULE3) level mode fires at configured active state
// (RULE4) equipment holds level two fields at least
// (RULE5) edge mode fires on rising edge only
// (RULE6) polarity applies in level mode only
// (RULE7) each activation issues its assigned action
// (RULE8) off action disables the input
// (RULE9) three serial port enables gate control
// (RULE10) any-field runs start next field
// (RULE11) odd/even runs wait for matching field
// (RULE12) save and recall run start defaults
// (RULE13) save and recall external control defaults
// (RULE14) sync, sample per field, one pulse
// (RULE15) reset loads factory defaults, inputs off
module gtr_top (
  input wire CORE_CLK, // system clock, 200 MHz
  input wire RST_N, // synchronous reset, active low
  input wire CE, // clock enable, freezes all state when low
  input wire [3:0] GPI_IN, // trigger input lines
  input wire FIELD_TICK, // one-cycle pulse at each field start
  input wire FIELD_ODD, // parity of the field that starts at FIELD_TICK
  input wire RUN_REQ, // run request pulse from the effect engine
  input wire [2:0] SER_REQ, // control requests from editor, switcher, aux
  output wire [3:0] ACT_VALID, // one-cycle action pulse per input
  output wire [15:0] ACT_CODE, // action code per input, 4 bits each
  output wire RUN_START, // one-cycle effect run start
  output wire RUN_PENDING, // run waits for its field
  output wire [2:0] SER_EN, // serial port enables
  output reg [2:0] SER_ACCEPT, // serial requests let through
  output wire IRQ, // level interrupt
  input wire [7:0] S_AXI_AWADDR, // write address
  input wire S_AXI_AWVALID, // write address valid
  output wire S_AXI_AWREADY, // write address ready
  input wire [31:0] S_AXI_WDATA, // write data
  input wire [3:0] S_AXI_WSTRB, // write byte strobes
  input wire S_AXI_WVALID, // write data valid
  output wire S_AXI_WREADY, // write data ready
  output reg [1:0] S_AXI_BRESP, // write response
  output reg S_AXI_BVALID, // write response valid
  input wire S_AXI_BREADY, // write response ready
  input wire [7:0] S_AXI_ARADDR, // read address
  input wire S_AXI_ARVALID, // read address valid
  output wire S_AXI_ARREADY, // read address ready
  output reg [31:0] S_AXI_RDATA, // read data
  output reg [1:0] S_AXI_RRESP, // read response
  output reg S_AXI_RVALID, // read data valid
  input wire S_AXI_RREADY // read data ready
);

`include "gtr_regs.vh"

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [31:0] gtr_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      gtr_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          gtr_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // codes above the last action count as off
  function gtr_act_on;
    input [3:0] code;
    begin
      gtr_act_on = (code != `GTR_ACT_OFF) && (code <= `GTR_ACT_REV_FIELD);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [1:0] run_mode_reg;
  reg [1:0] run_mode_next;
  reg [1:0] user_run_reg;
  reg [1:0] user_run_next;
  reg [2:0] ser_en_reg;
  reg [2:0] ser_en_next;
  reg [2:0] user_ser_reg;
  reg [2:0] user_ser_next;
  reg [31:0] gpi_cfg_reg;
  reg [31:0] gpi_cfg_next;
  reg [31:0] user_gpi_reg;
  reg [31:0] user_gpi_next;
  reg [4:0] status_reg;
  reg [4:0] status_next;
  reg [4:0] mask_reg;
  reg [4:0] mask_next;
  reg sw_run_req;

  reg aw_have_reg;
  reg [7:0] aw_addr_reg;
  reg w_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire [3:0] fire;
  wire [3:0] sampled;
  wire run_start_w;
  wire run_pending_w;
  wire gpi_run;
  wire do_write;
  wire [31:0] wmask;
  wire [31:0] cmd_bits;
  wire [31:0] mask_merge;

  ////////////////////////////////////////////////////////////////////////////
  // trigger channels

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      wire [7:0] cfg;
      assign cfg = gpi_cfg_reg[g*`GTR_CFG_LANE +: `GTR_CFG_LANE];
      gtr_gpi_chan u_chan ( // (RULE1)
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .gpi_pin(GPI_IN[g]),
        .field_tick(FIELD_TICK),
        .mode_edge(cfg[`GTR_CFG_EDGE_BIT]),
        .pol_high(cfg[`GTR_CFG_POL_BIT]),
        .enabled(gtr_act_on(cfg[`GTR_CFG_ACT_MSB:`GTR_CFG_ACT_LSB])), // (RULE8)
        .act_code(cfg[`GTR_CFG_ACT_MSB:`GTR_CFG_ACT_LSB]),
        .fire(fire[g]),
        .fire_code(ACT_CODE[g*4 +: 4]),
        .sampled(sampled[g])
      );
    end
  endgenerate

  assign ACT_VALID = fire;

  // an input assigned to run also asks the scheduler for a run
  assign gpi_run = (fire[0] && (ACT_CODE[3:0] == `GTR_ACT_RUN)) ||
                   (fire[1] && (ACT_CODE[7:4] == `GTR_ACT_RUN)) ||
                   (fire[2] && (ACT_CODE[11:8] == `GTR_ACT_RUN)) ||
                   (fire[3] && (ACT_CODE[15:12] == `GTR_ACT_RUN)); // (RULE7)

  ////////////////////////////////////////////////////////////////////////////
  // run start scheduler

  gtr_run_start u_run (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .field_tick(FIELD_TICK),
    .field_odd(FIELD_ODD),
    .run_mode(run_mode_reg),
    .req(RUN_REQ | sw_run_req | gpi_run),
    .start(run_start_w),
    .pending(run_pending_w)
  );

  assign RUN_START = run_start_w;
  assign RUN_PENDING = run_pending_w;

  ////////////////////////////////////////////////////////////////////////////
  // serial port gating

  assign SER_EN = ser_en_reg;

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      SER_ACCEPT <= 3'h0;
    end else if (CE) begin
      SER_ACCEPT <= SER_REQ & ser_en_reg; // (RULE9)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  // address and data are taken in either order, then the write happens once
  assign S_AXI_AWREADY = CE & ~aw_have_reg & ~S_AXI_BVALID;
  assign S_AXI_WREADY = CE & ~w_have_reg & ~S_AXI_BVALID;
  assign do_write = aw_have_reg & w_have_reg & ~S_AXI_BVALID;
  assign wmask = gtr_merge(32'h00000000, 32'hffffffff, w_strb_reg);
  // the mask register is only as wide as the status layout; upper lanes are dropped
  assign mask_merge = gtr_merge({27'h0, mask_reg}, w_data_reg, w_strb_reg);
  assign cmd_bits = (do_write && (aw_addr_reg == `GTR_OFF_CMD)) ? (w_data_reg & wmask) :
                    32'h00000000;

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `GTR_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        case (aw_addr_reg)
          `GTR_OFF_CTRL, `GTR_OFF_GPI_CFG, `GTR_OFF_CMD,
          `GTR_OFF_STATUS, `GTR_OFF_MASK: S_AXI_BRESP <= `GTR_RESP_OKAY;
          default: S_AXI_BRESP <= `GTR_RESP_SLVERR;
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, defaults and interrupt registers

  always @* begin
    run_mode_next = run_mode_reg;
    ser_en_next = ser_en_reg;
    gpi_cfg_next = gpi_cfg_reg;
    user_run_next = user_run_reg;
    user_ser_next = user_ser_reg;
    user_gpi_next = user_gpi_reg;
    mask_next = mask_reg;
    if (do_write && (aw_addr_reg == `GTR_OFF_CTRL)) begin
      if (w_strb_reg[0]) begin
        run_mode_next = w_data_reg[`GTR_CTRL_RUN_MSB:`GTR_CTRL_RUN_LSB];
        ser_en_next = w_data_reg[`GTR_CTRL_SER_MSB:`GTR_CTRL_SER_LSB]; // (RULE9)
      end
    end
    if (do_write && (aw_addr_reg == `GTR_OFF_GPI_CFG)) begin
      gpi_cfg_next = gtr_merge(gpi_cfg_reg, w_data_reg, w_strb_reg); // (RULE1)
    end
    if (do_write && (aw_addr_reg == `GTR_OFF_MASK)) begin
      mask_next = mask_merge[`GTR_ST_WIDTH-1:0];
    end
    // save takes the value in force before any recall of the same write
    if (cmd_bits[`GTR_CMD_RUN_SAVE]) begin
      user_run_next = run_mode_reg; // (RULE12)
    end
    if (cmd_bits[`GTR_CMD_RUN_USER]) begin
      run_mode_next = user_run_reg; // (RULE12)
    end
    if (cmd_bits[`GTR_CMD_RUN_FACT]) begin
      run_mode_next = `GTR_FACT_RUN; // (RULE12)
    end
    if (cmd_bits[`GTR_CMD_EXT_SAVE]) begin
      user_ser_next = ser_en_reg; // (RULE13)
      user_gpi_next = gpi_cfg_reg;
    end
    if (cmd_bits[`GTR_CMD_EXT_USER]) begin
      ser_en_next = user_ser_reg; // (RULE13)
      gpi_cfg_next = user_gpi_reg;
    end
    if (cmd_bits[`GTR_CMD_EXT_FACT]) begin
      ser_en_next = `GTR_FACT_SER; // (RULE13)
      gpi_cfg_next = `GTR_FACT_GPI;
    end
  end

  // a new event outranks a one written in the same cycle
  always @* begin
    status_next = status_reg;
    if (do_write && (aw_addr_reg == `GTR_OFF_STATUS) && w_strb_reg[0]) begin
      status_next = status_reg & ~w_data_reg[`GTR_ST_WIDTH-1:0];
    end
    status_next[`GTR_ST_GPI_MSB:`GTR_ST_GPI_LSB] =
      status_next[`GTR_ST_GPI_MSB:`GTR_ST_GPI_LSB] | fire;
    status_next[`GTR_ST_RUN_BIT] = status_next[`GTR_ST_RUN_BIT] | run_start_w;
  end

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      run_mode_reg <= `GTR_FACT_RUN; // (RULE15)
      ser_en_reg <= `GTR_FACT_SER; // (RULE15)
      gpi_cfg_reg <= `GTR_FACT_GPI; // (RULE15)
      user_run_reg <= `GTR_FACT_RUN;
      user_ser_reg <= `GTR_FACT_SER;
      user_gpi_reg <= `GTR_FACT_GPI;
      status_reg <= 5'h0;
      mask_reg <= `GTR_RST_MASK;
      sw_run_req <= 1'b0;
    end else if (CE) begin
      run_mode_reg <= run_mode_next;
      ser_en_reg <= ser_en_next;
      gpi_cfg_reg <= gpi_cfg_next;
      user_run_reg <= user_run_next;
      user_ser_reg <= user_ser_next;
      user_gpi_reg <= user_gpi_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      sw_run_req <= cmd_bits[`GTR_CMD_RUN_REQ];
    end
  end

  assign IRQ = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  assign S_AXI_ARREADY = CE & ~S_AXI_RVALID;

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `GTR_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `GTR_RESP_OKAY;
        case ({S_AXI_ARADDR[7:2], 2'b00})
          `GTR_OFF_CTRL: S_AXI_RDATA <= {25'h0, ser_en_reg, 2'b00, run_mode_reg};
          `GTR_OFF_GPI_CFG: S_AXI_RDATA <= gpi_cfg_reg;
          `GTR_OFF_CMD: S_AXI_RDATA <= 32'h00000000;
          `GTR_OFF_STATUS: S_AXI_RDATA <= {27'h0, status_reg};
          `GTR_OFF_MASK: S_AXI_RDATA <= {27'h0, mask_reg};
          `GTR_OFF_STATE: S_AXI_RDATA <= {26'h0, sampled, FIELD_ODD, run_pending_w};
          default: begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `GTR_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule

// file: verif/gtr_top_monitor.sv
// concurrent checks on the trigger block ports
module gtr_top_monitor (
  input wire CORE_CLK, // clock
  input wire RST_N, // reset, active low
  input wire FIELD_TICK, // field start
  input wire RUN_REQ, // run request
  input wire [2:0] SER_REQ, // serial requests
  input wire [3:0] ACT_VALID, // action pulses
  input wire RUN_START, // run start
  input wire RUN_PENDING, // run waiting
  input wire [2:0] SER_EN, // port enables
  input wire [2:0] SER_ACCEPT, // gated requests
  input wire IRQ, // interrupt
  input wire S_AXI_ARVALID, // read address valid
  input wire S_AXI_ARREADY, // read address ready
  input wire [1:0] S_AXI_BRESP, // write response
  input wire S_AXI_BVALID, // write response valid
  input wire S_AXI_BREADY, // write response ready
  input wire S_AXI_RVALID // read valid
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  property p_act_tick; ACT_VALID != 4'h0 |-> $past(FIELD_TICK); endproperty
  a_act_tick: assert property (p_act_tick) else $error("action off a tick");
  property p_start; RUN_START |-> $past(FIELD_TICK) && $past(RUN_PENDING); endproperty
  a_start: assert property (p_start) else $error("start without pending tick");
  property p_req; RUN_REQ && !FIELD_TICK |=> RUN_PENDING; endproperty
  a_req: assert property (p_req) else $error("request not pending");
  property p_hold; RUN_PENDING && !FIELD_TICK |=> RUN_PENDING; endproperty
  a_hold: assert property (p_hold) else $error("pending dropped");
  property p_ser; 1'b1 |=> SER_ACCEPT == $past(SER_REQ & SER_EN); endproperty
  a_ser: assert property (p_ser) else $error("serial gate wrong");
  // a new interrupt needs a fresh event or a register write behind it
  property p_irq; $rose(IRQ) |-> S_AXI_BVALID || $past(ACT_VALID != 4'h0 || RUN_START); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_rst; $rose(RST_N) |-> SER_EN == 3'h7 && !IRQ && !RUN_PENDING; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rlat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  c_act: cover property (ACT_VALID == 4'hb);
  c_run: cover property (RUN_START);
  c_irq: cover property ($rose(IRQ));
endmodule

bind gtr_top gtr_top_monitor u_mon (.*);

// file: verif/gtr_gpi_equip.sv
// external equipment: field reference and contact closure lines
module gtr_gpi_equip #(parameter int FLD = 16) (
  input wire clk, // system clock
  input wire [3:0] want, // levels asked by the bench
  output logic [3:0] line, // trigger lines
  output logic tick, // field start pulse
  output logic odd // parity of the starting field
);
  int cnt = 0;
  initial begin
    line = 4'h0;
    tick = 1'b0;
    odd = 1'b0;
  end
  always @(posedge clk) begin
    cnt <= (cnt == FLD - 1) ? 0 : cnt + 1;
    tick <= (cnt == FLD - 1);
    if (cnt == FLD - 1)
      odd <= !odd;
    // lines move only early in a field, far from the tick, and are held whole fields
    if (cnt == 1)
      line <= want;
  end
endmodule

// file: verif/gtr_top_bench.sv
// self-checking bench for the trigger block
module gtr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, RUN_REQ = 1'b0;
  logic [3:0] GPI_IN, ACT_VALID, S_AXI_WSTRB = 4'hf, want = 4'h0;
  logic FIELD_TICK, FIELD_ODD, RUN_START, RUN_PENDING, IRQ;
  logic [2:0] SER_REQ = 3'h0, SER_EN, SER_ACCEPT;
  logic [15:0] ACT_CODE;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int n_errors = 0, total_checks = 0;
  always #2.5 CORE_CLK = ~CORE_CLK;
  gtr_top dut (.*);
  gtr_gpi_equip equip (.clk(CORE_CLK), .want(want), .line(GPI_IN), .tick(FIELD_TICK), .odd(FIELD_ODD));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo;
    chk(32'h0, 32'h1);
    tally_and_finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CORE_CLK);
      if (S_AXI_AWREADY === 1'b1)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1)
        S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID === 1'b1)
        break;
    end
    if (n == 40)
      tmo;
    S_AXI_BREADY <= 1'b0;
    chk(S_AXI_BRESP, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CORE_CLK);
      if (S_AXI_ARREADY === 1'b1)
        S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID === 1'b1)
        break;
    end
    if (n == 40)
      tmo;
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RDATA, e);
    chk(S_AXI_RRESP, er);
  endtask
  // returns the action pulses of the cycle right after the next field tick
  task automatic tk(output logic [3:0] v);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge CORE_CLK);
      if (FIELD_TICK === 1'b1)
        break;
    end
    if (n == 40)
      tmo;
    @(posedge CORE_CLK);
    v = ACT_VALID;
  endtask
  task automatic fl(input int k, input logic [3:0] e);
    logic [3:0] v;
    repeat (k) begin
      tk(v);
      chk(v, e);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rdc(8'h00, 32'h70, 2'h0);
    rdc(8'h04, 32'h0, 2'h0);
    rdc(8'h10, 32'h0, 2'h0);
    chk(SER_EN, 3'h7);
    want <= 4'hf;
    fl(3, 4'h0);
    want <= 4'h0;
    fl(2, 4'h0);
  endtask
  task automatic t_edge;
    logic [31:0] cfg;
    logic [15:0] codes;
    for (int a = 1; a < 15; a++) begin
      for (int n = 0; n < 4; n++) begin
        codes[4*n+:4] = 4'((a + n - 1) % 14 + 1);
        cfg[8*n+:8] = {2'b0, n[0], 1'b1, codes[4*n+:4]};
      end
      wr(8'h04, cfg, 2'h0);
      want <= 4'h0;
      fl(2, 4'h0);
      want <= 4'hf;
      fl(1, 4'h0);
      fl(1, 4'hf);
      chk(ACT_CODE, codes);
    end
  endtask
  task automatic t_level;
    want <= 4'h2;
    fl(2, 4'h0);
    wr(8'h04, 32'h25100423, 2'h0);
    fl(1, 4'h0);
    want <= 4'hd;
    fl(2, 4'h0);
    fl(1, 4'hb);
    fl(2, 4'h0);
    want <= 4'h2;
    fl(3, 4'h0);
    want <= 4'hd;
    fl(1, 4'h0);
    want <= 4'h2;
    fl(4, 4'h0);
  endtask
  task automatic t_run;
    int n, nt;
    logic par;
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 32'h70 | m, 2'h0);
      RUN_REQ <= 1'b1;
      @(posedge CORE_CLK);
      RUN_REQ <= 1'b0;
      nt = 0;
      par = 1'b0;
      for (n = 0; n < 80; n++) begin
        @(posedge CORE_CLK);
        if (RUN_START === 1'b1)
          break;
        if (FIELD_TICK === 1'b1) begin
          nt++;
          par = FIELD_ODD;
        end
      end
      if (n == 80)
        tmo;
      chk(m == 0 ? nt == 1 : nt <= 2 && par == (m == 1), 32'h1);
    end
  endtask
  task automatic t_dflt;
    wr(8'h00, 32'h21, 2'h0);
    wr(8'h08, 32'h09, 2'h0);
    wr(8'h00, 32'h52, 2'h0);
    wr(8'h04, 32'h0, 2'h0);
    wr(8'h08, 32'h12, 2'h0);
    rdc(8'h00, 32'h21, 2'h0);
    rdc(8'h04, 32'h25100423, 2'h0);
    chk(SER_EN, 3'h2);
    wr(8'h08, 32'h24, 2'h0);
    rdc(8'h00, 32'h70, 2'h0);
    rdc(8'h04, 32'h0, 2'h0);
    // only the strobed lane moves; code 15 keeps input one off
    S_AXI_WSTRB <= 4'h2;
    wr(8'h04, 32'hffffffff, 2'h0);
    S_AXI_WSTRB <= 4'hf;
    rdc(8'h04, 32'h0000ff00, 2'h0);
  endtask
  task automatic t_ser;
    SER_REQ <= 3'h7;
    for (int e = 0; e < 8; e++) begin
      wr(8'h00, e << 4, 2'h0);
      @(posedge CORE_CLK);
      chk(SER_EN, e);
      chk(SER_ACCEPT, e);
    end
    SER_REQ <= 3'h0;
  endtask
  task automatic t_irq;
    int n;
    wr(8'h0c, 32'h1f, 2'h0);
    wr(8'h10, 32'h10, 2'h0);
    chk(IRQ, 1'b0);
    wr(8'h08, 32'h40, 2'h0);
    for (n = 0; n < 60 && IRQ !== 1'b1; n++)
      @(posedge CORE_CLK);
    if (n == 60)
      tmo;
    rdc(8'h0c, 32'h10, 2'h0);
    wr(8'h10, 32'h0, 2'h0);
    chk(IRQ, 1'b0);
    wr(8'h10, 32'h10, 2'h0);
    chk(IRQ, 1'b1);
    wr(8'h0c, 32'h10, 2'h0);
    chk(IRQ, 1'b0);
    wr(8'h14, 32'h1, 2'h2);
    rdc(8'h1c, 32'h0, 2'h2);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    t_reset;
    t_edge;
    t_level;
    t_run;
    t_dflt;
    t_ser;
    t_irq;
    tally_and_finish;
  end
endmodule
